// ==== logic/scs_secondary_current_sense.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1 - range code selects full scale and LSB
// RULE2 - software must not write range code 11
// RULE3 - gain polarity bit: zero positive, one negative
// RULE4 - five-bit gain trim corrects resistor tolerance
// RULE5 - software sets sensing position before offset trim
// RULE6 - offset polarity: one negative, zero positive
// RULE7 - six-bit offset trim corrects divider error
// RULE8 - digital trim calibrates reported current value
// RULE9 - calibrate position, then offset, then digital trim
// RULE10 - flag set when current exceeds limit
// RULE11 - software keeps limit at or below 254
module scs_secondary_current_sense
  import scs_pkg::*;
#(
  parameter int DATA_W = SCS_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWrEn,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  input  wire logic [DATA_W-1:0] rawSample,
  input  wire logic              rawSampleValid,
  output logic      [1:0]        fullScaleRangeSelect,
  output logic                   gainPolarity,
  output logic      [4:0]        gainTrim,
  output logic                   sensePositionSelect,
  output logic                   offsetPolarity,
  output logic      [5:0]        offsetTrim,
  output logic      [7:0]        currentValue,
  output logic                   currentValueValid,
  output logic                   overcurrentFlag
);

  if (DATA_W != 8) begin : gBadWidth
    $error("scs_secondary_current_sense supports DATA_W of 8 only");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] gainReg_ff;
  logic [7:0] offsetReg_ff;
  logic [7:0] dTrimReg_ff;
  logic [7:0] limitReg_ff;
  logic [7:0] value_ff;
  logic       valueValid_ff;
  logic       ocpFlag_ff;
  logic [7:0] rdData_ff;

  wire        wrGain   = regWrEn && (regAddr == SCS_ADDR_GAIN);
  wire        wrOffset = regWrEn && (regAddr == SCS_ADDR_OFFSET);
  wire        wrDTrim  = regWrEn && (regAddr == SCS_ADDR_DTRIM);
  wire        wrLimit  = regWrEn && (regAddr == SCS_ADDR_LIMIT);

  // reserved range code would leave the front end undefined, so the old range stays
  wire        rangeIsRsvd = (regWrData[SCS_RANGE_MSB:SCS_RANGE_LSB] == SCS_RANGE_RSVD); // RULE2
  wire [1:0]  nxt_range   = rangeIsRsvd ? gainReg_ff[SCS_RANGE_MSB:SCS_RANGE_LSB]
                                        : regWrData[SCS_RANGE_MSB:SCS_RANGE_LSB];
  wire [7:0]  nxt_gainReg = {nxt_range, regWrData[SCS_GAIN_POL_BIT:0]};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gainReg_ff   <= SCS_RST_GAIN;
      offsetReg_ff <= SCS_RST_OFFSET;
      dTrimReg_ff  <= SCS_RST_DTRIM;
      limitReg_ff  <= SCS_RST_LIMIT;
    end else begin
      if (wrGain) begin
        gainReg_ff <= nxt_gainReg; // RULE1
      end
      if (wrOffset) begin
        offsetReg_ff <= regWrData; // RULE7
      end
      if (wrDTrim) begin
        dTrimReg_ff <= regWrData;
      end
      if (wrLimit) begin
        limitReg_ff <= regWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // analog front-end controls

  assign fullScaleRangeSelect = gainReg_ff[SCS_RANGE_MSB:SCS_RANGE_LSB]; // RULE1
  assign gainPolarity         = gainReg_ff[SCS_GAIN_POL_BIT];            // RULE3
  assign gainTrim             = gainReg_ff[SCS_GAIN_MSB:0];              // RULE4
  assign sensePositionSelect  = offsetReg_ff[SCS_POS_BIT];
  assign offsetPolarity       = offsetReg_ff[SCS_OFS_POL_BIT];           // RULE6
  assign offsetTrim           = offsetReg_ff[SCS_OFS_MSB:0];             // RULE7

  ////////////////////////////////////////////////////////////////////////////////
  // digital trim: two's complement offset, saturated to 0..255

  function automatic logic [7:0] trimSat(input logic [7:0] raw, input logic [7:0] trim);
    logic signed [9:0] sum;
    sum = $signed({2'h0, raw}) + $signed({{2{trim[7]}}, trim});
    if (sum < 0) begin
      trimSat = 8'h00;
    end else if (sum > 10'sd255) begin
      trimSat = 8'hff;
    end else begin
      trimSat = sum[7:0];
    end
  endfunction

  wire [7:0] nxt_value = trimSat(rawSample, dTrimReg_ff); // RULE8
  // compare against the value being loaded so the flag never lags a sample
  wire [7:0] cmpValue  = rawSampleValid ? nxt_value : value_ff;
  wire       nxt_ocp   = (cmpValue > limitReg_ff); // RULE10

  always_ff @(posedge core_clk) begin
    if (srst) begin
      value_ff      <= SCS_RST_VALUE;
      valueValid_ff <= 1'b0;
      ocpFlag_ff    <= 1'b0;
    end else begin
      valueValid_ff <= rawSampleValid;
      ocpFlag_ff    <= nxt_ocp; // RULE10
      if (rawSampleValid) begin
        value_ff <= nxt_value; // RULE8
      end
    end
  end

  assign currentValue      = value_ff;
  assign currentValueValid = valueValid_ff;
  assign overcurrentFlag   = ocpFlag_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency

  wire [7:0] rdMux = (regAddr == SCS_ADDR_VALUE)  ? value_ff     :
                     (regAddr == SCS_ADDR_GAIN)   ? gainReg_ff   :
                     (regAddr == SCS_ADDR_OFFSET) ? offsetReg_ff :
                     (regAddr == SCS_ADDR_DTRIM)  ? dTrimReg_ff  :
                     (regAddr == SCS_ADDR_LIMIT)  ? limitReg_ff  : SCS_UNMAPPED_READ;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_ff <= SCS_RST_RDDATA;
    end else if (regRdEn) begin
      rdData_ff <= rdMux; // RULE8
    end
  end

  assign regRdData = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_range_keep: assert property ( // RULE2
    wrGain && regWrData[7:6] == 2'h3 |=> $stable(fullScaleRangeSelect))
    else $error("reserved range code changed the range");

  chk_range_load: assert property ( // RULE1
    wrGain && regWrData[7:6] != 2'h3 |=> fullScaleRangeSelect == $past(regWrData[7:6]))
    else $error("range field not loaded");

  chk_gain_pol: assert property ( // RULE3
    wrGain |=> gainPolarity == $past(regWrData[5]) ##1 ($stable(gainPolarity) || $past(wrGain)))
    else $error("gain polarity wrong");

  chk_gain_trim: assert property ( // RULE4
    wrGain |=> gainTrim == $past(regWrData[4:0]))
    else $error("gain trim not loaded");

  chk_offset_pol: assert property ( // RULE6
    wrOffset |=> offsetPolarity == $past(regWrData[6]) && sensePositionSelect == $past(regWrData[7]))
    else $error("offset polarity or position wrong");

  chk_offset_trim: assert property ( // RULE7
    wrOffset |=> offsetTrim == $past(regWrData[5:0]))
    else $error("offset trim not loaded");

  chk_trim_apply: assert property ( // RULE8
    rawSampleValid && !wrDTrim |=> currentValueValid &&
      currentValue == trimSat($past(rawSample), dTrimReg_ff))
    else $error("digital trim not applied");

  chk_read_value: assert property ( // RULE8
    regRdEn && regAddr == 8'h18 && !rawSampleValid |=> regRdData == currentValue)
    else $error("current value readback wrong");

  chk_ocp_flag: assert property ( // RULE10
    !rawSampleValid && !wrLimit ##1 !rawSampleValid |->
      overcurrentFlag == (currentValue > limitReg_ff))
    else $error("overcurrent flag disagrees with compare");

  chk_ocp_sample: assert property ( // RULE10
    rawSampleValid |=> overcurrentFlag == (currentValue > $past(limitReg_ff)))
    else $error("overcurrent flag lags the new sample");

  chk_sat_high: assert property ( // RULE8
    rawSampleValid && !dTrimReg_ff[7] && ({1'b0, rawSample} + {1'b0, dTrimReg_ff} > 9'h0ff) |=> currentValue == 8'hff)
    else $error("positive trim did not saturate high");

  chk_sat_low: assert property ( // RULE8
    rawSampleValid && dTrimReg_ff[7] && (rawSample < (~dTrimReg_ff + 8'h01)) |=> currentValue == 8'h00)
    else $error("negative trim did not saturate low");

  chk_value_hold: assert property ( // RULE8
    !rawSampleValid |=> $stable(currentValue))
    else $error("current value changed without a sample");

  chk_valid_pulse: assert property ( // RULE8
    !rawSampleValid |=> !currentValueValid)
    else $error("current valid without a sample");

  cov_ocp_rise:   cover property (!overcurrentFlag ##1 overcurrentFlag);
  cov_rsvd_range: cover property (wrGain && regWrData[7:6] == 2'h3);
  cov_sat_high:   cover property (rawSampleValid && nxt_value == 8'hff);
  cov_sat_low:    cover property (rawSampleValid && nxt_value == 8'h00 && rawSample != 8'h00);

endmodule
`default_nettype wire

// ==== logic/scs_pkg.sv ====
`default_nettype none
package scs_pkg;

  localparam int          SCS_DATA_W        = 8;
  localparam int          SCS_ADDR_W        = 8;

  // register offsets
  localparam logic [7:0]  SCS_ADDR_VALUE    = 8'h18;
  localparam logic [7:0]  SCS_ADDR_GAIN     = 8'h23;
  localparam logic [7:0]  SCS_ADDR_OFFSET   = 8'h24;
  localparam logic [7:0]  SCS_ADDR_DTRIM    = 8'h25;
  localparam logic [7:0]  SCS_ADDR_LIMIT    = 8'h26;

  // gain trim register fields
  localparam int          SCS_RANGE_MSB     = 7;
  localparam int          SCS_RANGE_LSB     = 6;
  localparam int          SCS_GAIN_POL_BIT  = 5;
  localparam int          SCS_GAIN_MSB      = 4;
  // analog offset trim register fields
  localparam int          SCS_POS_BIT       = 7;
  localparam int          SCS_OFS_POL_BIT   = 6;
  localparam int          SCS_OFS_MSB       = 5;

  // full-scale range codes: 37.5 mV / 15.26 uV, 75 mV / 30.52 uV, 150 mV / 61.04 uV
  localparam logic [1:0]  SCS_RANGE_37MV5   = 2'h0;
  localparam logic [1:0]  SCS_RANGE_75MV    = 2'h1;
  localparam logic [1:0]  SCS_RANGE_150MV   = 2'h2;
  localparam logic [1:0]  SCS_RANGE_RSVD    = 2'h3;

  // values after reset
  localparam logic [7:0]  SCS_RST_GAIN      = 8'h00;
  localparam logic [7:0]  SCS_RST_OFFSET    = 8'h00;
  localparam logic [7:0]  SCS_RST_DTRIM     = 8'h00;
  localparam logic [7:0]  SCS_RST_LIMIT     = 8'hfe;
  localparam logic [7:0]  SCS_RST_VALUE     = 8'h00;
  localparam logic [7:0]  SCS_UNMAPPED_READ = 8'h00;
  localparam logic [7:0]  SCS_RST_RDDATA    = 8'h00;

  // largest limit software may program
  localparam logic [7:0]  SCS_LIMIT_MAX     = 8'hfe;

endpackage
`default_nettype wire

// ==== test/scs_sense_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// front end behind the sense resistor: one sample per request
module scs_sense_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reqLevel,
  input  wire logic       reqFire,
  output logic      [7:0] rawSample,
  output logic            rawSampleValid
);
  logic       fireSeen;
  logic [7:0] levelSeen;
  initial begin
    rawSample = 8'h00;
    rawSampleValid = 1'b0;
  end
  // request taken at the edge, before the bench moves it one step later
  // data toggles between samples so a stale value is never reused
  always @(posedge core_clk) begin
    fireSeen = reqFire;
    levelSeen = reqLevel;
    #1;
    rawSample = fireSeen ? levelSeen : ~rawSample;
    rawSampleValid = fireSeen;
  end
endmodule
`default_nettype wire

// ==== test/tb_scs_secondary_current_sense.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_scs_secondary_current_sense
  import scs_pkg::*;
;
  logic       core_clk, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, reqFire = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, reqLevel = 8'h00;
  logic [7:0] regRdData, rawSample, currentValue;
  logic [5:0] offsetTrim;
  logic [4:0] gainTrim;
  logic [1:0] fullScaleRangeSelect;
  logic       rawSampleValid, gainPolarity, sensePositionSelect, offsetPolarity;
  logic       currentValueValid, overcurrentFlag;
  int         n_mismatch = 0, n_compared = 0;
  //////////////////////////////////////////////////////////////////////////////
  scs_secondary_current_sense scs_secondary_current_sense_inst (.core_clk(core_clk),
    .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .rawSample(rawSample),
    .rawSampleValid(rawSampleValid), .fullScaleRangeSelect(fullScaleRangeSelect),
    .gainPolarity(gainPolarity), .gainTrim(gainTrim),
    .sensePositionSelect(sensePositionSelect), .offsetPolarity(offsetPolarity),
    .offsetTrim(offsetTrim), .currentValue(currentValue),
    .currentValueValid(currentValueValid), .overcurrentFlag(overcurrentFlag));
  scs_sense_model scs_sense_model_inst (.core_clk(core_clk), .reqLevel(reqLevel),
    .reqFire(reqFire), .rawSample(rawSample), .rawSampleValid(rawSampleValid));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // strobes are one cycle wide and spaced so no signal changes twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #1 regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1 regRdEn = 1'b0;
    chk(regRdData, exp);
  endtask
  task automatic samp(input logic [7:0] v, input logic [7:0] ev, input logic ef);
    @(posedge core_clk);
    #1 reqLevel = v;
    reqFire = 1'b1;
    @(posedge core_clk);
    #1 reqFire = 1'b0;
    @(posedge core_clk);
    #1 chk(currentValue, ev);
    chk({6'h00, currentValueValid, overcurrentFlag}, {7'h01, ef});
    @(posedge core_clk);
    #1 chk({7'h00, currentValueValid}, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000 n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1 srst = 1'b0;
    rd(SCS_ADDR_GAIN, SCS_RST_GAIN);
    rd(SCS_ADDR_LIMIT, SCS_RST_LIMIT);
    rd(SCS_ADDR_VALUE, SCS_RST_VALUE);
    for (int c = 0; c < 3; c++) begin
      wr(SCS_ADDR_GAIN, {c[1:0], c[0], 5'(c + 3)});
      chk({6'h00, fullScaleRangeSelect}, 8'(c));
      chk({2'h0, gainPolarity, gainTrim}, {2'h0, c[0], 5'(c + 3)});
    end
    wr(SCS_ADDR_GAIN, 8'hdf);
    chk({6'h00, fullScaleRangeSelect}, 8'h02);
    chk({2'h0, gainPolarity, gainTrim}, 8'h1f);
    wr(SCS_ADDR_OFFSET, 8'hea);
    chk({sensePositionSelect, offsetPolarity, offsetTrim}, 8'hea);
    wr(SCS_ADDR_OFFSET, 8'h15);
    rd(SCS_ADDR_OFFSET, 8'h15);
    wr(SCS_ADDR_DTRIM, 8'h05);
    wr(SCS_ADDR_LIMIT, 8'h80);
    samp(8'h80, 8'h85, 1'b1);
    samp(8'h7b, 8'h80, 1'b0);
    rd(SCS_ADDR_VALUE, 8'h80);
    samp(8'h7c, 8'h81, 1'b1);
    wr(SCS_ADDR_LIMIT, SCS_LIMIT_MAX);
    @(posedge core_clk);
    #1 chk({7'h00, overcurrentFlag}, 8'h00);
    samp(8'hff, 8'hff, 1'b1);
    wr(SCS_ADDR_DTRIM, 8'hf0);
    samp(8'h08, 8'h00, 1'b0);
    rd(SCS_ADDR_DTRIM, 8'hf0);
    @(posedge core_clk);
    #1 srst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    chk(regRdData, SCS_RST_RDDATA);
    rd(SCS_ADDR_LIMIT, SCS_RST_LIMIT);
    rd(SCS_ADDR_GAIN, SCS_RST_GAIN);
    rd(SCS_ADDR_DTRIM, SCS_RST_DTRIM);
    wr(8'h30, 8'haa);
    rd(8'h30, SCS_UNMAPPED_READ);
    tally_and_finish();
  end
endmodule
`default_nettype wire
